// ---- rtl/rst_cause_pkg.sv ----
// shared constants and carriers for the reset cause flag block
package rst_cause_pkg;
  localparam int          FLAG_COUNT      = 8;
  localparam int          BROWN_OUT_BIT   = 0;
  localparam int          POR_BIT         = 1;
  localparam logic [7:0]  FLAGS_POR_VALUE = 8'h03;
  localparam logic [7:0]  FLAGS_CLEAR     = 8'h00;

  typedef struct packed {
    logic                  en;
    logic [FLAG_COUNT-1:0] mask;
    logic [FLAG_COUNT-1:0] data;
  } flag_write_t;

  typedef struct packed {
    logic [FLAG_COUNT-1:0] prev_req;
    logic [FLAG_COUNT-1:0] hit;
    logic                  reset_req;
  } pulse_state_t;

  typedef struct packed {
    logic [FLAG_COUNT-1:0] flags;
    logic                  settled;
  } cause_state_t;
endpackage : rst_cause_pkg

// ---- rtl/reset_cause_pulse.sv ----
// edge capture of reset cause requests and the core reset request
`timescale 1ns/1ns
`default_nettype none
module reset_cause_pulse (
  // clock and power-on reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  // cause requests, held level or pulse
  input  wire logic [rst_cause_pkg::FLAG_COUNT-1:0] cause_req,
  // captured causes
  output logic      [rst_cause_pkg::FLAG_COUNT-1:0] cause_hit,
  output logic                                      core_reset_req
);
  rst_cause_pkg::pulse_state_t state;
  rst_cause_pkg::pulse_state_t next_state;
  logic [rst_cause_pkg::FLAG_COUNT-1:0] rise;

  // a held request counts once, so a long reset pulse sets its flag once
  always_comb begin
    rise                 = cause_req & ~state.prev_req;
    next_state           = state;
    next_state.prev_req  = cause_req;
    next_state.hit       = rise;
    next_state.reset_req = |rise;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cause_hit      = state.hit;
  assign core_reset_req = state.reset_req;

  // reset request only ever comes from a cause request edge
  req_from_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    core_reset_req |-> ($past(cause_req) & ~$past(state.prev_req)) != '0)
    else $error("core reset request without a cause edge");

  hit_one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cause_req & state.prev_req) != '0
    |=> (cause_hit & $past(cause_req & state.prev_req)) == '0)
    else $error("held cause captured twice");

endmodule : reset_cause_pulse
`default_nettype wire

// ---- rtl/reset_cause_flags.sv ----
// reset cause status flags with software read and write port
//
// Operation
// - every reset cause sets its own flag
// - power-on clears all, sets power-on, brown-out
// - software may write any flag either way
// - software setting a flag never requests reset
`timescale 1ns/1ns
`default_nettype none
module reset_cause_flags (
  // clock and power-on reset
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  // reset cause requests from watchdog, traps, brown-out and the rest
  input  wire logic [rst_cause_pkg::FLAG_COUNT-1:0] cause_req,
  // software write port
  input  wire rst_cause_pkg::flag_write_t           sw_write,
  // status and reset request
  output logic      [rst_cause_pkg::FLAG_COUNT-1:0] reset_cause_register,
  output logic                                      brown_out_reset_flag,
  output logic                                      core_reset_req
);
  rst_cause_pkg::cause_state_t state;
  rst_cause_pkg::cause_state_t next_state;
  logic [rst_cause_pkg::FLAG_COUNT-1:0] cause_hit;
  logic [rst_cause_pkg::FLAG_COUNT-1:0] wr_mask;

  // the core reset request is derived from cause requests only
  reset_cause_pulse u_pulse (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .cause_req      (cause_req),
    .cause_hit      (cause_hit),
    .core_reset_req (core_reset_req)
  );

  function automatic logic [rst_cause_pkg::FLAG_COUNT-1:0] apply_write(
    input logic [rst_cause_pkg::FLAG_COUNT-1:0] cur,
    input logic [rst_cause_pkg::FLAG_COUNT-1:0] mask,
    input logic [rst_cause_pkg::FLAG_COUNT-1:0] data
  );
    apply_write = (cur & ~mask) | (data & mask);
  endfunction : apply_write

  always_comb begin
    wr_mask            = sw_write.en ? sw_write.mask : rst_cause_pkg::FLAGS_CLEAR;
    next_state         = state;
    next_state.settled = 1'b1;
    // software write first, held until changed again
    next_state.flags   = apply_write(state.flags, wr_mask, sw_write.data);
    // a cause arriving with a clear still sets its flag; others untouched
    next_state.flags   = next_state.flags | cause_hit;
  end

  // power-on and a software write of zero are the only events that clear flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.flags   <= rst_cause_pkg::FLAGS_POR_VALUE;
      state.settled <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // software is expected to clear flags after reading; nothing here enforces it
  assign reset_cause_register = state.flags;
  assign brown_out_reset_flag = state.flags[rst_cause_pkg::BROWN_OUT_BIT];

  por_value_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !state.settled |-> reset_cause_register == rst_cause_pkg::FLAGS_POR_VALUE)
    else $error("flags after power-on not at power-on value");

  cause_sets_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cause_hit != '0 |=> (reset_cause_register & $past(cause_hit)) == $past(cause_hit))
    else $error("reset cause did not set its flag");

  set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cause_hit & wr_mask & ~sw_write.data) != '0
    |=> (reset_cause_register & $past(cause_hit)) == $past(cause_hit))
    else $error("software clear beat a reset cause");

  sw_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sw_write.en |=> ((reset_cause_register ^ $past(sw_write.data))
                     & $past(sw_write.mask) & ~$past(cause_hit)) == '0)
    else $error("software write not taken");

  write_holds_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sw_write.en && cause_hit == '0) ##1 (!sw_write.en && cause_hit == '0) [*3]
    |-> $stable(reset_cause_register))
    else $error("written flags did not hold");

  other_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sw_write.en |=> (reset_cause_register & ~$past(cause_hit))
                     == ($past(reset_cause_register) & ~$past(cause_hit)))
    else $error("cause disturbed other flags");

  sw_no_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sw_write.en && cause_req == '0) ##1 (cause_req == '0) |=> !core_reset_req)
    else $error("software write produced reset request");

  brown_out_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cause_hit[rst_cause_pkg::BROWN_OUT_BIT] |=> brown_out_reset_flag)
    else $error("brown-out flag not set");

  brown_out_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (brown_out_reset_flag && !(sw_write.en && sw_write.mask[rst_cause_pkg::BROWN_OUT_BIT]))
    |=> brown_out_reset_flag)
    else $error("brown-out flag lost without a write");

  por_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !state.settled
    |-> brown_out_reset_flag && reset_cause_register[rst_cause_pkg::POR_BIT])
    else $error("power-on and brown-out flags not both set");

  // a flag changes only through a cause or a software write
  idle_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!sw_write.en && cause_hit == '0)
    |=> $stable(reset_cause_register))
    else $error("flags moved with no cause and no write");

  no_self_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sw_write.en
    |=> (reset_cause_register & $past(reset_cause_register)) == $past(reset_cause_register))
    else $error("flag cleared without a software write");

  cause_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cause_hit != '0 && !sw_write.en)
    |=> (reset_cause_register & $past(reset_cause_register)) == $past(reset_cause_register))
    else $error("a cause cleared another flag");

  mask_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sw_write.en |=> ((reset_cause_register ^ $past(reset_cause_register))
                     & ~$past(wr_mask) & ~$past(cause_hit)) == '0)
    else $error("write touched an unselected flag");

  write_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sw_write.en
    |=> (~reset_cause_register & $past(sw_write.mask & sw_write.data)) == '0)
    else $error("written one did not land");

  write_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sw_write.en
    |=> (reset_cause_register & $past(sw_write.mask & ~sw_write.data & ~cause_hit)) == '0)
    else $error("written zero did not land");

  full_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sw_write.en && sw_write.mask == 8'hFF && cause_hit == '0)
    |=> reset_cause_register == $past(sw_write.data))
    else $error("full write not held as written");

  // the reset request travels with a captured cause, never with a write
  req_hit_pair_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    core_reset_req == (cause_hit != '0))
    else $error("reset request apart from a captured cause");

  set_no_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sw_write.en && (sw_write.mask & sw_write.data) != '0 && cause_req == '0)
    |=> !core_reset_req)
    else $error("software set produced reset request");

  quiet_no_req_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cause_req == '0
    |=> !core_reset_req)
    else $error("reset request with no cause request");

  hit_needs_req_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cause_hit != '0
    |-> (cause_hit & ~$past(cause_req)) == '0)
    else $error("cause captured that was never requested");

  settled_stays_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state.settled
    |=> state.settled)
    else $error("power-on state came back without reset");

  // per bit, so a fault in one flag names its own position
  for (genvar i = 0; i < rst_cause_pkg::FLAG_COUNT; i++) begin : g_flag
    flag_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(reset_cause_register[i])
      |-> $past(cause_hit[i] || (sw_write.en && sw_write.mask[i] && sw_write.data[i])))
      else $error("flag rose without cause or write");

    flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cause_hit[i]
      |=> reset_cause_register[i])
      else $error("captured cause left its flag clear");

    flag_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(reset_cause_register[i])
      |-> $past(sw_write.en && sw_write.mask[i] && !sw_write.data[i] && !cause_hit[i]))
      else $error("flag fell without a clearing write");

    flag_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!sw_write.en && !cause_hit[i])
      |=> $stable(reset_cause_register[i]))
      else $error("untouched flag changed");
  end

  sw_clear_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    sw_write.en && sw_write.mask == 8'hFF && sw_write.data == 8'h00 ##1
    reset_cause_register == 8'h00);

  accumulate_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    cause_hit != '0 ##[1:20] cause_hit != '0 && (cause_hit & reset_cause_register) == '0);

  set_clear_race_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    (cause_hit & wr_mask & ~sw_write.data) != '0);

  write_set_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    sw_write.en && (sw_write.mask & sw_write.data) != '0 ##1 reset_cause_register == 8'hFF);

  power_on_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    !state.settled ##1 state.settled);

endmodule : reset_cause_flags
`default_nettype wire

// ---- tb/tb_reset_cause_flags.sv ----
// self-checking bench for the reset cause flag block
`timescale 1ns/1ns
`default_nettype none
module tb_reset_cause_flags;
  logic                       core_clk;
  logic                       rst_n;
  logic [7:0]                 cause_req;
  rst_cause_pkg::flag_write_t sw_write;
  logic [7:0]                 reset_cause_register;
  logic                       brown_out_reset_flag;
  logic                       core_reset_req;
  int                         errors = 0;
  int                         compares = 0;
  int                         pulses = 0;
  int                         cycles = 0;

  reset_cause_flags uut (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .cause_req            (cause_req),
    .sw_write             (sw_write),
    .reset_cause_register (reset_cause_register),
    .brown_out_reset_flag (brown_out_reset_flag),
    .core_reset_req       (core_reset_req)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // counting pulses, not timing them, keeps the bench tolerant of latency
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (core_reset_req === 1'b1) pulses <= pulses + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // settle past the edge so outputs are read after they land
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : wait_cyc

  task automatic wr(input logic [7:0] m, input logic [7:0] d);
    @(posedge core_clk) sw_write <= '{1'b1, m, d};
    @(posedge core_clk) sw_write.en <= 1'b0;
    wait_cyc(2);
  endtask : wr

  task automatic t_write();
    int p0;
    p0 = pulses;
    wr(8'hFF, 8'hFF);
    chk("flags", reset_cause_register, 8'hFF);
    wr(8'h0F, 8'h5A);
    chk("flags", reset_cause_register, 8'hFA);
    wr(8'hFF, 8'h00);
    chk("flags", reset_cause_register, 8'h00);
    chk("write_pulses", 8'(pulses - p0), 8'h00);
    $display("test write done");
  endtask : t_write

  task automatic t_causes();
    int p0;
    for (int i = 0; i < 8; i++) begin
      p0 = pulses;
      @(posedge core_clk) cause_req <= 8'h01 << i;
      @(posedge core_clk) cause_req <= 8'h00;
      wait_cyc(3);
      chk("flags", reset_cause_register, 8'((9'h002 << i) - 9'h001));
      chk("cause_pulses", 8'(pulses - p0), 8'h01);
    end
    chk("brown_out", {7'h00, brown_out_reset_flag}, 8'h01);
    wr(8'hFF, 8'h00);
    p0 = pulses;
    // a held level must count once only
    @(posedge core_clk) cause_req <= 8'h20;
    wait_cyc(6);
    @(posedge core_clk) cause_req <= 8'h00;
    wait_cyc(3);
    chk("held_pulses", 8'(pulses - p0), 8'h01);
    chk("flags", reset_cause_register, 8'h20);
    $display("test causes done");
  endtask : t_causes

  task automatic t_power_on();
    wr(8'hFF, 8'hFC);
    @(posedge core_clk) rst_n <= 1'b0;
    wait_cyc(2);
    chk("flags", reset_cause_register, 8'h03);
    chk("reset_req", {7'h00, core_reset_req}, 8'h00);
    @(posedge core_clk) rst_n <= 1'b1;
    wait_cyc(2);
    chk("flags", reset_cause_register, 8'h03);
    chk("brown_out", {7'h00, brown_out_reset_flag}, 8'h01);
    $display("test power_on done");
  endtask : t_power_on

  // a software clear landing with a captured cause must lose
  task automatic t_race();
    @(posedge core_clk) cause_req <= 8'h08;
    @(posedge core_clk) begin
      cause_req <= 8'h00;
      sw_write  <= '{1'b1, 8'hFF, 8'h00};
    end
    @(posedge core_clk) sw_write.en <= 1'b0;
    wait_cyc(2);
    chk("race_flags", reset_cause_register, 8'h08);
    $display("test race done");
  endtask : t_race

  // a cause held high through power-on counts once at the first edge
  task automatic t_held_reset();
    int p0;
    p0 = pulses;
    @(posedge core_clk) rst_n <= 1'b0;
    @(posedge core_clk) cause_req <= 8'h20;
    @(posedge core_clk) rst_n <= 1'b1;
    wait_cyc(4);
    chk("held_reset_flags", reset_cause_register, 8'h23);
    chk("held_reset_pulses", 8'(pulses - p0), 8'h01);
    @(posedge core_clk) cause_req <= 8'h00;
    wait_cyc(2);
    $display("test held_reset done");
  endtask : t_held_reset

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial begin
    rst_n = 1'b0;
    cause_req = 8'h00;
    sw_write = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_cyc(1);
    chk("flags", reset_cause_register, 8'h03);
    t_write();
    t_causes();
    t_race();
    t_power_on();
    t_held_reset();
    complete_run();
  end
endmodule : tb_reset_cause_flags
`default_nettype wire
